// file: mpd_pkg.sv
// constants for the multiphase divider with pseudorandom spread modulation
// assumes hclk runs at twice the master oscillator rate (one hclk edge per master half period)
package mpd_pkg;
   // three-level select codes from the analog level detectors
   localparam logic [1:0] LVL_LOW   = 2'h0;
   localparam logic [1:0] LVL_MID   = 2'h1;
   localparam logic [1:0] LVL_HIGH  = 2'h2;

   // divider ratios, counted in hclk cycles (master half periods) per divider output half period
   localparam logic [6:0] DIV_BY1   = 7'h01;
   localparam logic [6:0] DIV_BY10  = 7'h0a;
   localparam logic [6:0] DIV_BY100 = 7'h64;

   // hclk cycles per master oscillator period
   localparam int unsigned HCLK_PER_MASTER = 2;
   localparam int unsigned MOD_DIV_MASTER  = 3200;
   localparam int unsigned MOD_STEP_HCLK   = MOD_DIV_MASTER * HCLK_PER_MASTER;

   // sequence generator
   localparam int unsigned LFSR_W       = 9;
   localparam int unsigned CODE_W       = 7;
   localparam int unsigned LFSR_TAP_HI  = 8;
   localparam int unsigned LFSR_TAP_LO  = 4;
   localparam logic [8:0]  LFSR_SEED    = 9'h001;

   // register map
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_STATUS  = 8'h04;
   localparam logic        CTRL_RESET   = 1'h1;
   localparam int unsigned CTRL_SPREAD_BIT = 0;
   localparam int unsigned ST_DIV_LSB   = 0;
   localparam int unsigned ST_PH_LSB    = 4;
   localparam int unsigned ST_SLEW_BIT  = 8;
   localparam int unsigned ST_MOD_BIT   = 9;
   localparam int unsigned ST_CODE_LSB  = 16;

   typedef enum logic [2:0] {
      MPD_DIV1   = 3'b001,
      MPD_DIV10  = 3'b010,
      MPD_DIV100 = 3'b100
   } mpd_div_t;

   typedef enum logic [2:0] {
      MPD_PH2 = 3'b001,
      MPD_PH3 = 3'b010,
      MPD_PH4 = 3'b100
   } mpd_ph_t;
endpackage : mpd_pkg

// file: mpd_top.sv
// divider, multiphase generator and spread-modulation sequencer with an ahb-lite register slave
// assumes select levels arrive already decoded and synchronous to hclk; hclk is twice the master rate
//
// Overview of operation
// - master clock divided by 1, 10 or 100 per divider select, feeding the phase generator
// - low divider select: ratio one, master clock forwarded unchanged
// - floating or middle divider select: divide by ten
// - high divider select: divide by one hundred
// - phase select low, middle, high gives 2-, 3-, 4-phase mode
// - 2-phase: 50% duty outputs, second output exact inverse of first
// - 2-phase: third output copies first, fourth copies second
// - 2-phase: no further division, output rate equals divider rate
// - 3-phase: first three outputs one-third duty, fourth held low
// - 3-phase: shift register, each output lags previous by 120 degrees
// - 3-phase: output rate is divider rate over three
// - 4-phase: all 50% duty, each output lags previous by 90 degrees
// - 4-phase: flip-flops generate outputs at divider rate over four
// - slew limiting asserted for ratio ten or hundred, released at ratio one
// - modulation sequence from a nine-bit linear feedback shift register
// - sequence repeats after 512 shift-register clocks
// - low seven register bits go to the dac, updated every shift clock
// - shift register clocked every 3200 master clock periods
// - grounded modulation control disables spreading and stops the sequencer
// - down spread only; zero code gives maximum frequency
`timescale 1ns/1ps
`default_nettype none
module mpd_top
   import mpd_pkg::*;
#(
   parameter int unsigned MOD_STEP_CYCLES = MOD_STEP_HCLK
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic [1:0]        divider_select,
   input  wire logic [1:0]        phase_select,
   input  wire logic              modulation_control,
   output logic                   phase_out_a,
   output logic                   phase_out_b,
   output logic                   phase_out_c,
   output logic                   phase_out_d,
   output logic                   slew_limit,
   output logic [CODE_W-1:0]      modulation_code
);
   localparam int unsigned STEP_W = $clog2(MOD_STEP_CYCLES);

   if (MOD_STEP_CYCLES < 2) begin : g_chk
      $error("MOD_STEP_CYCLES must be at least 2");
   end

   typedef struct packed {
      mpd_div_t            div_mode;
      mpd_ph_t             ph_mode;
      logic [6:0]          div_cnt;
      logic                div_clk;
      logic [3:0]          ph_sr;
      logic [3:0]          outs;
      logic                slew;
      logic [STEP_W-1:0]   step_cnt;
      logic [LFSR_W-1:0]   lfsr;
      logic [CODE_W-1:0]   code;
      logic                spread_en;
      logic                wr_pend;
      logic [31:0]         rdata;
   } mpd_state_t;

   mpd_state_t st_r;
   mpd_state_t st_nxt;

   function automatic mpd_div_t mpd_dec_div(input logic [1:0] lvl);
      case (lvl)
         LVL_LOW:  mpd_dec_div = MPD_DIV1;
         LVL_HIGH: mpd_dec_div = MPD_DIV100;
         default:  mpd_dec_div = MPD_DIV10;
      endcase
   endfunction : mpd_dec_div

   function automatic mpd_ph_t mpd_dec_ph(input logic [1:0] lvl);
      case (lvl)
         LVL_LOW:  mpd_dec_ph = MPD_PH2;
         LVL_HIGH: mpd_dec_ph = MPD_PH4;
         default:  mpd_dec_ph = MPD_PH3;
      endcase
   endfunction : mpd_dec_ph

   logic [6:0]        div_n;
   logic              tick;
   logic              rise;
   logic              mod_on;
   logic [LFSR_W-1:0] lfsr_adv;
   logic              addr_ok;
   logic [31:0]       status_w;

   always_comb begin
      st_nxt = st_r;
      // undefined level code 2'b11 is read as floating
      st_nxt.div_mode = mpd_dec_div(divider_select);
      st_nxt.ph_mode  = mpd_dec_ph(phase_select);

      case (st_r.div_mode)
         MPD_DIV1:   div_n = DIV_BY1;
         MPD_DIV10:  div_n = DIV_BY10;
         MPD_DIV100: div_n = DIV_BY100;
         default:    div_n = DIV_BY10;
      endcase

      // each tick is one half period of the divider output
      tick = (st_r.div_cnt == div_n - 7'h01);
      rise = tick && !st_r.div_clk;
      if (st_nxt.div_mode != st_r.div_mode) begin
         st_nxt.div_cnt = 7'h00;
      end else if (tick) begin
         st_nxt.div_cnt = 7'h00;
      end else begin
         st_nxt.div_cnt = st_r.div_cnt + 7'h01;
      end
      if (tick) begin
         st_nxt.div_clk = !st_r.div_clk;
      end

      // mode change restarts the pattern so no illegal phase state survives
      if (st_nxt.ph_mode != st_r.ph_mode) begin
         st_nxt.ph_sr = (st_nxt.ph_mode == MPD_PH3) ? 4'h1 : 4'h0;
      end else begin
         case (st_r.ph_mode)
            MPD_PH3: begin
               if (rise) begin
                  st_nxt.ph_sr = {1'b0, st_r.ph_sr[1:0], st_r.ph_sr[2]};
               end
            end
            MPD_PH4: begin
               // two-stage johnson stepped on each divider rise: four steps per period, 90 degrees each
               if (rise) begin
                  st_nxt.ph_sr = {2'b00, st_r.ph_sr[0], !st_r.ph_sr[1]};
               end
            end
            default: st_nxt.ph_sr = 4'h0;
         endcase
      end

      case (st_nxt.ph_mode)
         MPD_PH2: st_nxt.outs = {!st_nxt.div_clk, st_nxt.div_clk,
                                 !st_nxt.div_clk, st_nxt.div_clk};
         MPD_PH3: st_nxt.outs = {1'b0, st_nxt.ph_sr[2:0]};
         MPD_PH4: st_nxt.outs = {!st_nxt.ph_sr[1], !st_nxt.ph_sr[0],
                                 st_nxt.ph_sr[1:0]};
         default: st_nxt.outs = 4'h0;
      endcase

      st_nxt.slew = (st_nxt.div_mode != MPD_DIV1);

      // de bruijn fix-up makes the zero state part of the loop: 512 states, no lock-up
      lfsr_adv = {st_r.lfsr[LFSR_W-2:0],
                  st_r.lfsr[LFSR_TAP_HI] ^ st_r.lfsr[LFSR_TAP_LO]
                  ^ (st_r.lfsr[LFSR_W-2:0] == 8'h00)};
      mod_on = modulation_control && st_r.spread_en;
      if (!mod_on) begin
         st_nxt.step_cnt = '0;
         st_nxt.lfsr     = LFSR_SEED;
         st_nxt.code     = '0;
      end else if (st_r.step_cnt == STEP_W'(MOD_STEP_CYCLES - 1)) begin
         st_nxt.step_cnt = '0;
         st_nxt.lfsr     = lfsr_adv;
         st_nxt.code     = lfsr_adv[CODE_W-1:0];
      end else begin
         st_nxt.step_cnt = st_r.step_cnt + STEP_W'(1);
      end

      status_w = 32'h0;
      status_w[ST_DIV_LSB +: 3]      = st_r.div_mode;
      status_w[ST_PH_LSB +: 3]       = st_r.ph_mode;
      status_w[ST_SLEW_BIT]          = st_r.slew;
      status_w[ST_MOD_BIT]           = mod_on;
      status_w[ST_CODE_LSB +: CODE_W] = st_r.code;

      // zero-wait slave; read data latched at the address phase
      addr_ok = hsel && hready && htrans[1];
      if (st_r.wr_pend) begin
         st_nxt.spread_en = hwdata[CTRL_SPREAD_BIT];
      end
      st_nxt.wr_pend = addr_ok && hwrite && (haddr[7:0] == ADDR_CTRL) && (haddr[31:8] == 24'h0);
      if (addr_ok && !hwrite) begin
         if (haddr[31:8] != 24'h0) begin
            st_nxt.rdata = 32'h0;
         end else if (haddr[7:0] == ADDR_CTRL) begin
            st_nxt.rdata = {31'h0, st_r.spread_en};
         end else if (haddr[7:0] == ADDR_STATUS) begin
            st_nxt.rdata = status_w;
         end else begin
            st_nxt.rdata = 32'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r.div_mode  <= MPD_DIV10;
         st_r.ph_mode   <= MPD_PH3;
         st_r.div_cnt   <= 7'h00;
         st_r.div_clk   <= 1'b0;
         st_r.ph_sr     <= 4'h1;
         st_r.outs      <= 4'h0;
         st_r.slew      <= 1'b1;
         st_r.step_cnt  <= '0;
         st_r.lfsr      <= LFSR_SEED;
         st_r.code      <= '0;
         st_r.spread_en <= CTRL_RESET;
         st_r.wr_pend   <= 1'b0;
         st_r.rdata     <= 32'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign hrdata          = st_r.rdata;
   assign phase_out_a     = st_r.outs[0];
   assign phase_out_b     = st_r.outs[1];
   assign phase_out_c     = st_r.outs[2];
   assign phase_out_d     = st_r.outs[3];
   assign slew_limit      = st_r.slew;
   assign modulation_code = st_r.code;
endmodule : mpd_top
`default_nettype wire

// file: mpd_sva.sv
// checker for phase outputs, slew control and modulation code of mpd_top
// assumes selects are held steady by the driver between mode changes
`timescale 1ns/1ps
`default_nettype none
module mpd_chk
   import mpd_pkg::*;
#(
   parameter int unsigned MOD_STEP_CYCLES = 8
) (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic [1:0]        divider_select,
   input wire logic [1:0]        phase_select,
   input wire logic              modulation_control,
   input wire logic              phase_out_a,
   input wire logic              phase_out_b,
   input wire logic              phase_out_c,
   input wire logic              phase_out_d,
   input wire logic              slew_limit,
   input wire logic [CODE_W-1:0] modulation_code
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_two; (phase_select == LVL_LOW)[*6]; endsequence
   sequence s_fast4; (phase_select == LVL_HIGH && divider_select == LVL_LOW)[*8]; endsequence
   sequence s_fast3; (phase_select == LVL_MID && divider_select == LVL_LOW)[*8]; endsequence
   property p_inv; s_two |-> phase_out_b != phase_out_a; endproperty
   property p_copy; s_two |-> phase_out_c == phase_out_a && phase_out_d == phase_out_b; endproperty
   property p_tog; (phase_select == LVL_LOW && divider_select == LVL_LOW)[*6] |-> phase_out_a != $past(phase_out_a);
   endproperty
   property p_dlow; (phase_select == LVL_MID)[*6] |-> !phase_out_d; endproperty
   property p_lag3; s_fast3 |-> phase_out_b == $past(phase_out_a, 2) && phase_out_c == $past(phase_out_b, 2);
   endproperty
   property p_lag4; s_fast4 |-> phase_out_d == $past(phase_out_c, 2) && phase_out_b == $past(phase_out_a, 2);
   endproperty
   property p_slew; $stable(divider_select)[*3] |-> slew_limit == (divider_select != LVL_LOW); endproperty
   property p_off; (!modulation_control)[*2] |-> modulation_code == 7'h00; endproperty
   // hold length sized for the short step used in simulation
   property p_hold; $changed(modulation_code) && modulation_control
      |=> ($stable(modulation_code) || !modulation_control)[*7]; endproperty
   a_inv: assert property (p_inv) else $error("b not inverse of a");
   a_copy: assert property (p_copy) else $error("c or d not a copy");
   a_tog: assert property (p_tog) else $error("a not toggling at full rate");
   a_dlow: assert property (p_dlow) else $error("d not low in three phase");
   a_lag3: assert property (p_lag3) else $error("three phase lag wrong");
   a_lag4: assert property (p_lag4) else $error("four phase lag wrong");
   a_slew: assert property (p_slew) else $error("slew control wrong");
   a_off: assert property (p_off) else $error("code not zero when off");
   a_hold: assert property (p_hold) else $error("code changed inside a step");
endmodule : mpd_chk
bind mpd_top mpd_chk #(.MOD_STEP_CYCLES(MOD_STEP_CYCLES)) u_mpd_chk (.hclk, .hresetn, .divider_select,
   .phase_select, .modulation_control, .phase_out_a, .phase_out_b, .phase_out_c, .phase_out_d,
   .slew_limit, .modulation_code);
`default_nettype wire

// file: mpd_load.sv
// downstream clocked load: measures period and high time of one phase output
// assumes the output is sampled on hclk; counts are in hclk cycles
`timescale 1ns/1ps
`default_nettype none
module mpd_load (
   input wire logic  hclk,
   input wire logic  clk_in,
   output var logic [15:0] period,
   output var logic [15:0] high
);
   logic [15:0] cnt_r = 16'h0;
   logic [15:0] hi_r  = 16'h0;
   logic        prev_r = 1'b0;
   // latches only whole periods, so a restart after a mode change settles in one period
   always_ff @(posedge hclk) begin
      prev_r <= clk_in;
      if (clk_in && !prev_r) begin
         period <= cnt_r;
         high   <= hi_r;
         cnt_r  <= 16'h1;
         hi_r   <= 16'h1;
      end else begin
         cnt_r <= cnt_r + 16'h1;
         hi_r  <= hi_r + {15'h0, clk_in};
      end
   end
endmodule : mpd_load
`default_nettype wire

// file: tb_mpd_top.sv
// testbench for mpd_top: mode table, status register and sequence check
// assumes a zero wait slave and a short modulation step
`timescale 1ns/1ps
`default_nettype none
module tb_mpd_top;
   import mpd_pkg::*;
   localparam int unsigned STEP = 8;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, modulation_control, slew_limit;
   logic phase_out_a, phase_out_b, phase_out_c, phase_out_d;
   logic [31:0] haddr, hwdata, hrdata, q, e;
   logic [1:0]  htrans, divider_select, phase_select;
   logic [2:0]  hsize;
   logic [6:0]  modulation_code;
   logic [15:0] per, hig;
   logic [8:0]  l;
   logic [1:0]  lv[3] = '{LVL_LOW, LVL_MID, LVL_HIGH};
   int ns[3] = '{1, 10, 100};
   int pf[3] = '{2, 6, 8};
   int hf[3] = '{1, 2, 4};
   int fail_count, total_checks, k;
   assign hready = hreadyout;
   mpd_top #(.MOD_STEP_CYCLES(STEP)) u_mpd_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hreadyout, .hresp, .hrdata, .divider_select, .phase_select, .modulation_control,
      .phase_out_a, .phase_out_b, .phase_out_c, .phase_out_d, .slew_limit, .modulation_code);
   mpd_load u_mpd_load (.hclk, .clk_in(phase_out_a), .period(per), .high(hig));
   initial hclk = 1'b0;
   always #25 hclk = ~hclk;
   function automatic logic [8:0] nxt(input logic [8:0] s);
      return {s[7:0], s[8] ^ s[4] ^ (s[7:0] == 8'h00)};
   endfunction : nxt
   task automatic chk(input string what, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr, hsize} <= {1'b1, 2'h2, w, a, 3'h2};
      do @(posedge hclk); while (hready !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : ahb
   task give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (20000) @(posedge hclk);
      fail_count++;
      give_verdict();
   end
   initial begin
      {hresetn, hsel, htrans, hwrite, haddr, hwdata, hsize} = '0;
      {divider_select, phase_select, modulation_control} = '0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, {24'h0, ADDR_CTRL}, 32'h0, q);
      chk("ctrl reset", 32'h1, q);
      ahb(1'b0, 32'h10, 32'h0, q);
      chk("unmapped", 32'h0, q);
      $display("register test done");
      for (int i = 0; i < 3; i++) for (int j = 0; j < 3; j++) begin
         @(posedge hclk);
         {divider_select, phase_select} <= {lv[i], lv[j]};
         repeat (3 * ns[i] * pf[j] + 20) @(posedge hclk);
         chk("period", 32'(ns[i] * pf[j]), {16'h0, per});
         chk("high", 32'(ns[i] * hf[j]), {16'h0, hig});
         e = (32'h1 << i) | (32'h10 << j) | (i != 0 ? 32'h100 : 32'h0);
         ahb(1'b0, {24'h0, ADDR_STATUS}, 32'h0, q);
         chk("status", e, q);
      end
      $display("mode table test done");
      ahb(1'b1, {24'h0, ADDR_CTRL}, 32'h0, q);
      ahb(1'b0, {24'h0, ADDR_CTRL}, 32'h0, q);
      chk("ctrl written", 32'h0, q);
      @(posedge hclk);
      {divider_select, phase_select, modulation_control} <= {LVL_LOW, LVL_LOW, 1'b1};
      repeat (3 * STEP) @(posedge hclk);
      chk("code held off", 32'h0, {25'h0, modulation_code});
      ahb(1'b1, {24'h0, ADDR_CTRL}, 32'h1, q);
      k = 0;
      while (modulation_code === 7'h00 && k < 100) begin
         @(negedge hclk);
         k++;
      end
      repeat (STEP / 2) @(negedge hclk);
      l = nxt(LFSR_SEED);
      // one full cycle plus one step, so the wrap back to the start is compared too
      for (int s = 0; s < 513; s++) begin
         chk("code", {25'h0, l[6:0]}, {25'h0, modulation_code});
         l = nxt(l);
         repeat (STEP) @(negedge hclk);
      end
      @(posedge hclk);
      modulation_control <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("code off", 32'h0, {25'h0, modulation_code});
      $display("modulation test done");
      give_verdict();
   end
endmodule : tb_mpd_top
`default_nettype wire
